// ---- include/cps_pkg.sv ----
package cps_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [5:0] ADDR_INDIRECT_PORT = 6'h00;
   localparam logic [5:0] ADDR_TIMER_COUNT   = 6'h01;
   localparam logic [5:0] ADDR_PC_LOW_BYTE   = 6'h02;
   localparam logic [5:0] ADDR_STATUS_FLAGS  = 6'h03;
   localparam logic [5:0] ADDR_INDIRECT_PTR  = 6'h04;
   localparam logic [5:0] ADDR_PC_HIGH_BUF   = 6'h0a;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CFG_SOURCE_BIT = 5;
   localparam int CFG_EDGE_BIT   = 4;
   localparam int CFG_PSA_BIT    = 3;
   localparam int ST_CARRY       = 0;
   localparam int ST_HALF_CARRY  = 1;
   localparam int ST_ZERO        = 2;
   localparam int ST_POWERDOWN   = 3;
   localparam int ST_TIMEOUT     = 4;
   localparam int BUF_PAGE_BIT   = 2;
   localparam int PTR_ADDR_BITS  = 6;

   // ****************************************
   // reset values and sizes
   // ****************************************
   localparam logic [7:0] TIMER_CFG_RESET = 8'hff;
   localparam logic [7:0] STATUS_RESET    = 8'h18;
   localparam logic [7:0] PTR_RESET       = 8'hc0;
   localparam logic [2:0] BUF_RESET       = 3'h0;
   localparam int         STACK_DEPTH     = 5;
   localparam int         PRESCALE_BITS   = 8;

   // ****************************************
   // program counter operations
   // ****************************************
   typedef enum logic [2:0] {
      CPS_PC_STEP       = 3'h0,
      CPS_PC_NEAR_JUMP  = 3'h1,
      CPS_PC_NEAR_CALL  = 3'h3,
      CPS_PC_FAR_JUMP   = 3'h2,
      CPS_PC_FAR_CALL   = 3'h6,
      CPS_PC_RETURN     = 3'h7,
      CPS_PC_LOW_WRITE  = 3'h5,
      CPS_PC_TABLE      = 3'h4
   } cps_pc_op_t;
endpackage

// ---- hdl/cps_core.sv ----
`timescale 1ns/100ps
// What this block does
// - timer is 8-bit; option bit 5 picks instruction clock or external pin
// - with external pin, option bit 4 picks rising or falling edge
// - option bit 3 low attaches prescaler; timer write then clears prescaler
// - program counter 9 or 11 bits, five-entry return stack same width
// - low pc byte is a register; high bits load only from high buffer, branch word or return stack
// - counter holds next address and steps by one unless loaded
// - near jump loads bits 9:0 from word, bit 10 from buffer bit 2
// - near call pushes next address, then loads like near jump
// - far jump loads 10:0 from word and page bit into buffer bit 2
// - far call pushes, loads 10:0 and buffer bit 2 from word
// - the return pops counter, buffer untouched
// - low byte write takes 7:0 from data and 10:8 from buffer
// - table lookup takes 7:0 from alu, keeps 9:8, bit 10 from counter
// - flags follow result when affected; timeout and powerdown not writable
// - carry set on add carry; subtraction carry means no borrow
// - rotates load carry from bit shifted out
// - half carry on carry out of bit 3; subtract means no borrow
// - zero flag set when result zero, else cleared
// - powerdown flag set at power-up and watchdog clear, cleared by sleep
// - timeout set at power-up, watchdog clear, sleep; cleared on overflow
// - pointer bits 5:0 give indirect data address
// - bank bits read ones on small variant, select bank on large
// - indirect with pointer zero reads zero and writes nothing
// - bank bits encode bank number directly
module cps_core #(
   parameter int PC_WIDTH = 11,
   parameter bit LARGE    = 1'b1
) (
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   input  wire logic                  timer_ext_clock_pin_i,
   input  wire logic [7:0]            timer_cfg_i,
   input  wire cps_pkg::cps_pc_op_t   pc_op_i,
   input  wire logic [10:0]           instr_addr_i,
   input  wire logic [7:0]            alu_result_i,
   input  wire logic                  reg_wr_i,
   input  wire logic [5:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  flag_zero_upd_i,
   input  wire logic                  flag_carry_upd_i,
   input  wire logic                  flag_zero_i,
   input  wire logic                  flag_carry_i,
   input  wire logic                  flag_half_carry_i,
   input  wire logic                  watchdog_clear_instr_i,
   input  wire logic                  sleep_instr_i,
   input  wire logic                  watchdog_overflow_i,
   output logic [PC_WIDTH-1:0]        pc_o,
   output logic [7:0]                 reg_rdata_o,
   output logic [7:0]                 timer_count_o,
   output logic [7:0]                 status_flags_o,
   output logic [7:0]                 indirect_pointer_o,
   output logic [cps_pkg::PRESCALE_BITS-1:0] prescaler_o,
   output logic                       indirect_null_o,
   output logic [1:0]                 data_bank_o,
   output logic [5:0]                 indirect_addr_o
);
   import cps_pkg::*;
   localparam int PRESCALE_BITS_W = PRESCALE_BITS;

   // ****************************************
   // external timer pin synchroniser
   // ****************************************
   logic       pin_meta_r;
   logic       pin_sync_r;
   logic       pin_prev_r;
   always_ff @(posedge clk_i) begin
      pin_meta_r <= timer_ext_clock_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
   end

   // ****************************************
   // timer and prescaler
   // ****************************************
   logic [7:0]                 timer_r;
   logic [7:0]                 timer_nxt;
   logic [PRESCALE_BITS_W-1:0] presc_r;
   logic [PRESCALE_BITS_W-1:0] presc_nxt;
   wire  logic rise_seen   = pin_sync_r & ~pin_prev_r;
   wire  logic fall_seen   = ~pin_sync_r & pin_prev_r;
   // edge select high counts falling edges
   wire  logic pin_tick    = timer_cfg_i[CFG_EDGE_BIT] ? fall_seen : rise_seen;
   wire  logic timer_tick  = timer_cfg_i[CFG_SOURCE_BIT] ? pin_tick : 1'b1;
   wire  logic presc_on    = ~timer_cfg_i[CFG_PSA_BIT];
   wire  logic timer_wr    = reg_wr_i && (reg_addr_i == ADDR_TIMER_COUNT);
   // prescaler divides by one more than two to the power of option bits 2:0
   wire  logic [2:0] ps_sel = timer_cfg_i[2:0];
   wire  logic presc_done  = presc_r[ps_sel] & timer_tick;
   wire  logic timer_step  = presc_on ? presc_done : timer_tick;

   assign presc_nxt = (timer_wr && presc_on) ? '0 :
                      (presc_on && timer_tick) ?
                         (presc_done ? '0 : presc_r + PRESCALE_BITS_W'(1)) : presc_r;
   assign timer_nxt = timer_wr ? reg_wdata_i : timer_step ? timer_r + 8'h01 : timer_r;

   // ****************************************
   // program counter and stack
   // ****************************************
   logic [PC_WIDTH-1:0] pc_r;
   logic [PC_WIDTH-1:0] pc_nxt;
   logic [PC_WIDTH-1:0] stack_r [STACK_DEPTH];
   logic [2:0]          sp_r;
   logic [2:0]          sp_nxt;
   logic [2:0]          buf_r;
   logic [2:0]          buf_nxt;

   function automatic logic [2:0] wrap_inc(input logic [2:0] p);
      return (p == 3'(STACK_DEPTH - 1)) ? 3'h0 : p + 3'h1;
   endfunction
   function automatic logic [2:0] wrap_dec(input logic [2:0] p);
      return (p == 3'h0) ? 3'(STACK_DEPTH - 1) : p - 3'h1;
   endfunction

   wire logic [10:0] pc_w       = 11'(pc_r);
   wire logic [10:0] pc_inc     = 11'(pc_r + PC_WIDTH'(1));
   wire logic        pcl_wr     = reg_wr_i && (reg_addr_i == ADDR_PC_LOW_BYTE);
   wire logic        buf_wr     = reg_wr_i && (reg_addr_i == ADDR_PC_HIGH_BUF);
   wire logic        is_push    = (pc_op_i == CPS_PC_NEAR_CALL) || (pc_op_i == CPS_PC_FAR_CALL);
   wire logic        is_pop     = (pc_op_i == CPS_PC_RETURN);
   wire logic [10:0] near_tgt   = {buf_r[BUF_PAGE_BIT], instr_addr_i[9:0]};
   wire logic [10:0] table_tgt  = {pc_w[10:8], alu_result_i};
   wire logic [10:0] low_tgt    = {buf_r, reg_wdata_i};
   wire logic [10:0] pop_tgt    = 11'(stack_r[wrap_dec(sp_r)]);

   logic [10:0] pc_sel;
   always_comb begin
      unique case (pc_op_i)
         CPS_PC_NEAR_JUMP, CPS_PC_NEAR_CALL: pc_sel = near_tgt;
         CPS_PC_FAR_JUMP, CPS_PC_FAR_CALL:   pc_sel = instr_addr_i;
         CPS_PC_RETURN:                      pc_sel = pop_tgt;
         CPS_PC_TABLE:                       pc_sel = table_tgt;
         CPS_PC_LOW_WRITE:                   pc_sel = {buf_r, alu_result_i};
         default:                            pc_sel = pcl_wr ? low_tgt : pc_inc;
      endcase
   end
   assign pc_nxt  = PC_WIDTH'(pc_sel);
   assign sp_nxt  = is_push ? wrap_inc(sp_r) : is_pop ? wrap_dec(sp_r) : sp_r;
   // far branches rewrite only the page bit; the high bits never flow back into the buffer
   assign buf_nxt = ((pc_op_i == CPS_PC_FAR_JUMP) || (pc_op_i == CPS_PC_FAR_CALL)) ?
                    {instr_addr_i[10], buf_r[1:0]} :
                    buf_wr ? (LARGE ? reg_wdata_i[2:0] : {2'h0, reg_wdata_i[0]}) : buf_r;

   // ****************************************
   // status flags
   // ****************************************
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   wire  logic status_wr = reg_wr_i && (reg_addr_i == ADDR_STATUS_FLAGS);
   logic [7:0] st_tmp;
   always_comb begin
      st_tmp = status_r;
      if (status_wr) begin
         st_tmp[7:5] = reg_wdata_i[7:5];
         st_tmp[2:0] = reg_wdata_i[2:0];
      end
      // flag updates from the result win over a direct write
      if (flag_zero_upd_i) st_tmp[ST_ZERO] = flag_zero_i;
      if (flag_carry_upd_i) begin
         st_tmp[ST_CARRY]      = flag_carry_i;
         st_tmp[ST_HALF_CARRY] = flag_half_carry_i;
      end
      if (sleep_instr_i) begin
         st_tmp[ST_POWERDOWN] = 1'b0;
         st_tmp[ST_TIMEOUT]   = 1'b1;
      end
      if (watchdog_clear_instr_i) begin
         st_tmp[ST_POWERDOWN] = 1'b1;
         st_tmp[ST_TIMEOUT]   = 1'b1;
      end
      if (watchdog_overflow_i) st_tmp[ST_TIMEOUT] = 1'b0;
      status_nxt = st_tmp;
   end

   // ****************************************
   // indirect pointer
   // ****************************************
   logic [7:0] ptr_r;
   logic [7:0] ptr_nxt;
   wire  logic ptr_wr = reg_wr_i && (reg_addr_i == ADDR_INDIRECT_PTR);
   assign ptr_nxt = ptr_wr ? (LARGE ? reg_wdata_i : {2'h3, reg_wdata_i[5:0]}) : ptr_r;
   wire  logic ptr_null = (ptr_r[PTR_ADDR_BITS-1:0] == 6'h00);

   // ****************************************
   // register read mux
   // ****************************************
   logic [7:0] rd_nxt;
   always_comb begin
      unique case (reg_addr_i)
         ADDR_TIMER_COUNT:  rd_nxt = timer_r;
         ADDR_PC_LOW_BYTE:  rd_nxt = pc_w[7:0];
         ADDR_STATUS_FLAGS: rd_nxt = status_r;
         ADDR_INDIRECT_PTR: rd_nxt = ptr_r;
         ADDR_PC_HIGH_BUF:  rd_nxt = {5'h00, buf_r};
         default:           rd_nxt = 8'h00;
      endcase
   end

   // ****************************************
   // state
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         timer_r  <= 8'h00;
         presc_r  <= '0;
         pc_r     <= '1;
         sp_r     <= 3'h0;
         buf_r    <= BUF_RESET;
         status_r <= STATUS_RESET;
         ptr_r    <= PTR_RESET;
      end else begin
         timer_r  <= timer_nxt;
         presc_r  <= presc_nxt;
         pc_r     <= pc_nxt;
         sp_r     <= sp_nxt;
         buf_r    <= buf_nxt;
         status_r <= status_nxt;
         ptr_r    <= ptr_nxt;
      end
   end

   // no reset on the stack itself: stale entries are what an underflow returns
   always_ff @(posedge clk_i) begin
      if (is_push) stack_r[sp_r] <= pc_r;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o        <= 8'h00;
         indirect_null_o    <= 1'b1;
         data_bank_o        <= 2'h0;
         indirect_addr_o    <= 6'h00;
      end else begin
         reg_rdata_o        <= rd_nxt;
         indirect_null_o    <= ptr_null;
         data_bank_o        <= LARGE ? ptr_r[7:6] : 2'h0;
         indirect_addr_o    <= ptr_r[PTR_ADDR_BITS-1:0];
      end
   end

   assign pc_o               = pc_r;
   assign timer_count_o      = timer_r;
   assign status_flags_o     = status_r;
   assign indirect_pointer_o = ptr_r;
   assign prescaler_o        = presc_r;

   // ****************************************
   // checks
   // ****************************************
   a_pc_steps: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_STEP && !pcl_wr) |=> pc_r == $past(pc_r) + PC_WIDTH'(1))
      else $error("pc did not step");
   a_far_page: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_FAR_JUMP) |=> buf_r[2] == $past(instr_addr_i[10]) && buf_r[1:0] == $past(buf_r[1:0]))
      else $error("far jump buffer wrong");
   a_call_ret: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_NEAR_CALL) ##1 (pc_op_i == CPS_PC_RETURN) |=> pc_r == $past(pc_r, 2))
      else $error("return address wrong");
   a_near_jump: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_NEAR_JUMP) |=> pc_r[9:0] == $past(instr_addr_i[9:0]) && $stable(buf_r))
      else $error("near jump wrong");
   a_table_keep: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_TABLE) |=> pc_r[7:0] == $past(alu_result_i))
      else $error("table low byte wrong");
   a_presc_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      (timer_wr && !timer_cfg_i[CFG_PSA_BIT]) |=> presc_r == '0)
      else $error("prescaler not cleared");
   a_sleep_flags: assert property (@(posedge clk_i) disable iff (reset_i)
      (sleep_instr_i && !watchdog_clear_instr_i) |=> !status_r[ST_POWERDOWN])
      else $error("sleep flag wrong");
   a_wdt_timeout: assert property (@(posedge clk_i) disable iff (reset_i)
      watchdog_overflow_i |=> !status_r[ST_TIMEOUT])
      else $error("timeout not cleared");
   a_no_tpd_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (status_wr && !sleep_instr_i && !watchdog_clear_instr_i && !watchdog_overflow_i) |=> $stable(status_r[4:3]))
      else $error("timeout or powerdown written");
   a_int_timer: assert property (@(posedge clk_i) disable iff (reset_i)
      (!timer_wr && !timer_cfg_i[CFG_SOURCE_BIT] && timer_cfg_i[CFG_PSA_BIT]) |=> timer_r == $past(timer_r) + 8'h01)
      else $error("timer not stepping");

   // ****************************************
   // checks on branches, flags, pointer and timer
   // ****************************************
   a_near_push: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_NEAR_CALL)
      |=> stack_r[$past(sp_r)] == $past(pc_r) && $stable(buf_r))
      else $error("near call push wrong");

   a_far_call: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_FAR_CALL)
      |=> pc_r == PC_WIDTH'($past(instr_addr_i)) && buf_r[2] == $past(instr_addr_i[10]))
      else $error("far call load wrong");

   a_far_jump_pc: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_FAR_JUMP)
      |=> pc_r == PC_WIDTH'($past(instr_addr_i)))
      else $error("far jump target wrong");

   a_ret_buf: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_RETURN && !buf_wr)
      |=> $stable(buf_r))
      else $error("return changed buffer");

   a_pcl_write: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_STEP && pcl_wr)
      |=> pc_r == PC_WIDTH'({$past(buf_r), $past(reg_wdata_i)}))
      else $error("low byte write wrong");

   a_alu_low: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_LOW_WRITE)
      |=> pc_r == PC_WIDTH'({$past(buf_r), $past(alu_result_i)}))
      else $error("alu low write wrong");

   a_table_high: assert property (@(posedge clk_i) disable iff (reset_i)
      (pc_op_i == CPS_PC_TABLE)
      |=> pc_r[PC_WIDTH-1:8] == $past(pc_r[PC_WIDTH-1:8]))
      else $error("table high bits wrong");

   a_buf_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      (!buf_wr && pc_op_i != CPS_PC_FAR_JUMP && pc_op_i != CPS_PC_FAR_CALL)
      |=> $stable(buf_r))
      else $error("buffer changed");

   a_carry_flag: assert property (@(posedge clk_i) disable iff (reset_i)
      flag_carry_upd_i
      |=> status_r[ST_CARRY] == $past(flag_carry_i))
      else $error("carry flag wrong");

   a_half_flag: assert property (@(posedge clk_i) disable iff (reset_i)
      flag_carry_upd_i
      |=> status_r[ST_HALF_CARRY] == $past(flag_half_carry_i))
      else $error("half carry flag wrong");

   a_zero_flag: assert property (@(posedge clk_i) disable iff (reset_i)
      flag_zero_upd_i
      |=> status_r[ST_ZERO] == $past(flag_zero_i))
      else $error("zero flag wrong");

   a_wdt_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      (watchdog_clear_instr_i && !watchdog_overflow_i)
      |=> status_r[4:3] == 2'h3)
      else $error("watchdog clear flags wrong");

   a_ind_addr: assert property (@(posedge clk_i) disable iff (reset_i)
      1'b1
      |=> indirect_addr_o == $past(ptr_r[PTR_ADDR_BITS-1:0]))
      else $error("indirect address wrong");

   a_null_flag: assert property (@(posedge clk_i) disable iff (reset_i)
      1'b1
      |=> indirect_null_o == $past(ptr_r[PTR_ADDR_BITS-1:0] == 6'h00))
      else $error("null pointer flag wrong");

   a_bank_bits: assert property (@(posedge clk_i) disable iff (reset_i)
      1'b1
      |=> data_bank_o == (LARGE ? $past(ptr_r[7:6]) : 2'h0))
      else $error("bank select wrong");

   a_ptr_write: assert property (@(posedge clk_i) disable iff (reset_i)
      ptr_wr
      |=> ptr_r[5:0] == $past(reg_wdata_i[5:0]) && (LARGE || ptr_r[7:6] == 2'h3))
      else $error("pointer write wrong");

   a_ext_rise: assert property (@(posedge clk_i) disable iff (reset_i)
      (timer_cfg_i[5:3] == 3'h5 && rise_seen && !timer_wr)
      |=> timer_r == $past(timer_r) + 8'h01)
      else $error("pin edge not counted");

   a_ext_idle: assert property (@(posedge clk_i) disable iff (reset_i)
      (timer_cfg_i[CFG_SOURCE_BIT] && timer_cfg_i[CFG_PSA_BIT] && !pin_tick && !timer_wr)
      |=> $stable(timer_r))
      else $error("timer moved without edge");

   a_stack_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
      is_push
      |=> sp_r == wrap_inc($past(sp_r)) && sp_r < 3'(STACK_DEPTH))
      else $error("stack pointer wrap wrong");
endmodule

// ---- test/cps_alu_model.sv ----
`timescale 1ns/100ps
// ****************************************
// alu partner: adds, subtracts, rotates and ands for the core
// ****************************************
module cps_alu_model (
   input  wire logic [2:0] op_i,
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       carry_in_i,
   input  wire logic       half_in_i,
   output logic [7:0]      result_o,
   output logic            zero_o,
   output logic            carry_o,
   output logic            half_carry_o
);
   // op: 0 add, 1 subtract, 2 rotate right, 3 rotate left, 4 and
   logic       sub;
   logic [7:0] b_eff;
   logic [8:0] sum;
   logic [4:0] nib;
   // subtract adds the two's complement, so carry set means no borrow
   assign sub          = (op_i == 3'h1);
   assign b_eff        = sub ? ~b_i : b_i;
   assign sum          = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, sub};
   assign nib          = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
   assign result_o     = (op_i == 3'h2) ? {carry_in_i, a_i[7:1]} :
                         (op_i == 3'h3) ? {a_i[6:0], carry_in_i} :
                         (op_i == 3'h4) ? (a_i & b_i) : sum[7:0];
   assign carry_o      = (op_i == 3'h2) ? a_i[0] : (op_i == 3'h3) ? a_i[7] :
                         (op_i == 3'h4) ? carry_in_i : sum[8];
   // rotates and logic leave half carry alone
   assign half_carry_o = (op_i < 3'h2) ? nib[4] : half_in_i;
   assign zero_o       = (result_o == 8'h00);
endmodule

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
   import cps_pkg::*;
   logic clk_i, reset_i, pin, reg_wr, zu, cu, wc, sl, ov, zero, carry, half, null_o;
   logic [7:0]  cfg, wdata, alu, rdata, tmr, st, ptr, pre, a, b;
   logic [5:0]  raddr, iaddr;
   logic [10:0] iword, pc;
   logic [2:0]  aop;
   logic [1:0]  bank;
   cps_pc_op_t  op;
   int          bad_count, checked, cycles, i;
   // op, a, b, expected {z,dc,c}, mask of flags that the op updates
   localparam logic [24:0] CASES [8] = '{
      {3'h0, 8'h0f, 8'h01, 3'h2, 3'h7}, {3'h0, 8'hff, 8'h01, 3'h7, 3'h7},
      {3'h1, 8'h05, 8'h03, 3'h3, 3'h7}, {3'h1, 8'h03, 8'h05, 3'h0, 3'h7},
      {3'h2, 8'h01, 8'h00, 3'h1, 3'h1}, {3'h3, 8'h40, 8'h00, 3'h0, 3'h1},
      {3'h4, 8'hf0, 8'h0f, 3'h4, 3'h4}, {3'h4, 8'hff, 8'h0f, 3'h0, 3'h4}};

   cps_alu_model alu_m (.op_i(aop), .a_i(a), .b_i(b), .carry_in_i(st[ST_CARRY]),
      .half_in_i(st[ST_HALF_CARRY]), .result_o(alu), .zero_o(zero), .carry_o(carry),
      .half_carry_o(half));
   cps_core dut (.clk_i(clk_i), .reset_i(reset_i), .timer_ext_clock_pin_i(pin), .timer_cfg_i(cfg),
      .pc_op_i(op), .instr_addr_i(iword), .alu_result_i(alu), .reg_wr_i(reg_wr), .reg_addr_i(raddr),
      .reg_wdata_i(wdata), .flag_zero_upd_i(zu), .flag_carry_upd_i(cu), .flag_zero_i(zero),
      .flag_carry_i(carry), .flag_half_carry_i(half), .watchdog_clear_instr_i(wc),
      .sleep_instr_i(sl), .watchdog_overflow_i(ov), .pc_o(pc), .reg_rdata_o(rdata),
      .timer_count_o(tmr), .status_flags_o(st), .indirect_pointer_o(ptr), .prescaler_o(pre),
      .indirect_null_o(null_o), .data_bank_o(bank), .indirect_addr_o(iaddr));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ****************************************
   // shared drivers; cyc, wr and rd set every control once, then pass one edge; idle passes n
   // ****************************************
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   task automatic ctl(cps_pc_op_t o, logic w, logic z, logic c, logic [2:0] p);
      op = o; reg_wr = w; zu = z; cu = c; {wc, sl, ov} = p;
   endtask
   task automatic cyc(cps_pc_op_t o, logic [10:0] t);
      ctl(o, 1'b0, 1'b0, 1'b0, 3'h0); iword = t; step();
   endtask
   task automatic wr(logic [5:0] ad, logic [7:0] d);
      ctl(CPS_PC_STEP, 1'b1, 1'b0, 1'b0, 3'h0); raddr = ad; wdata = d; step();
   endtask
   task automatic rd(logic [5:0] ad, output logic [7:0] d);
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h0); raddr = ad; step(); d = rdata;
   endtask
   task automatic idle(int n);
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h0); repeat (n) step();
   endtask
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk({5'h0, pc}, 16'h07ff);
      chk({st, ptr}, {STATUS_RESET, PTR_RESET});
      chk({tmr, pre}, 16'h0000);
      chk({15'h0, null_o}, 16'h0001);
      $display("reset test done");
   endtask
   task automatic t_status();
      wr(ADDR_STATUS_FLAGS, 8'he0); chk(st, 8'hf8);
      ctl(CPS_PC_STEP, 1'b1, 1'b1, 1'b1, 3'h0); aop = 3'h0; a = 8'h00; b = 8'h00;
      raddr = ADDR_STATUS_FLAGS; wdata = 8'h07; step(); chk(st, 8'h1c);
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h2); step(); chk(st, 8'h14);
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h1); step(); chk(st, 8'h04);
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h6); step(); chk(st, 8'h1c);
      $display("status test done");
   endtask
   task automatic t_flags();
      for (i = 0; i < 8; i++) begin
         {aop, a, b} = CASES[i][24:6];
         ctl(CPS_PC_STEP, 1'b0, CASES[i][2], CASES[i][0], 3'h0); step();
         chk({13'h0, st[2:0] & CASES[i][2:0]}, {13'h0, CASES[i][5:3]});
      end
      $display("flag test done");
   endtask
   task automatic t_pc_load();
      wr(ADDR_PC_HIGH_BUF, 8'h04);
      cyc(CPS_PC_NEAR_JUMP, 11'h123); chk({5'h0, pc}, 16'h0523);
      cyc(CPS_PC_NEAR_CALL, 11'h045); chk({5'h0, pc}, 16'h0445);
      idle(1); chk({5'h0, pc}, 16'h0446);
      cyc(CPS_PC_RETURN, 11'h000); chk({5'h0, pc}, 16'h0523);
      wr(ADDR_PC_HIGH_BUF, 8'h05); wr(ADDR_PC_LOW_BYTE, 8'h3c); chk({5'h0, pc}, 16'h053c);
      aop = 3'h0; a = 8'h9a; b = 8'h00;
      cyc(CPS_PC_LOW_WRITE, 11'h000); chk({5'h0, pc}, 16'h059a);
      wr(ADDR_PC_HIGH_BUF, 8'h00); a = 8'h77;
      cyc(CPS_PC_TABLE, 11'h000); chk({5'h0, pc}, 16'h0577);
      rd(ADDR_PC_LOW_BYTE, wdata); chk(wdata, 8'h77);
      wr(ADDR_PC_HIGH_BUF, 8'h07);
      cyc(CPS_PC_FAR_JUMP, 11'h0ab); chk({5'h0, pc}, 16'h00ab);
      rd(ADDR_PC_HIGH_BUF, wdata); chk(wdata, 8'h03);
      cyc(CPS_PC_FAR_CALL, 11'h6cd); chk({5'h0, pc}, 16'h06cd);
      rd(ADDR_PC_HIGH_BUF, wdata); chk(wdata, 8'h07);
      cyc(CPS_PC_RETURN, 11'h000); chk({5'h0, pc}, 16'h00ac);
      rd(ADDR_PC_HIGH_BUF, wdata); chk(wdata, 8'h07);
      $display("pc load test done");
   endtask
   task automatic t_stack();
      wr(ADDR_PC_HIGH_BUF, 8'h00);
      cyc(CPS_PC_NEAR_JUMP, 11'h200);
      for (i = 1; i <= 6; i++) cyc(CPS_PC_NEAR_CALL, 11'(i * 17));
      // six pushes into five entries: the newest five come back in order
      for (i = 5; i >= 1; i--) begin
         cyc(CPS_PC_RETURN, 11'h000); chk({5'h0, pc}, 16'(i * 17));
      end
      $display("stack test done");
   endtask
   task automatic t_pointer();
      wr(ADDR_INDIRECT_PTR, 8'h00); idle(1); chk({15'h0, null_o}, 16'h0001);
      rd(ADDR_INDIRECT_PORT, wdata); chk(wdata, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_INDIRECT_PTR, {i[1:0], 6'h2a}); idle(1);
         chk({bank, iaddr, 7'h0, null_o}, {i[1:0], 6'h2a, 8'h00});
         rd(ADDR_INDIRECT_PTR, wdata); chk(wdata, {i[1:0], 6'h2a});
      end
      rd(6'h3f, wdata); chk(wdata, 8'h00);
      $display("pointer test done");
   endtask
   task automatic t_timer();
      cfg = 8'h08; wr(ADDR_TIMER_COUNT, 8'h10); chk(tmr, 8'h10);
      idle(4); chk(tmr, 8'h14);
      cfg = 8'h28; wr(ADDR_TIMER_COUNT, 8'hff); idle(4); chk(tmr, 8'hff);
      pin = 1'b1; idle(5); chk(tmr, 8'h00);
      pin = 1'b0; idle(5); chk(tmr, 8'h00);
      cfg = 8'h38; pin = 1'b1; idle(5); chk(tmr, 8'h00);
      pin = 1'b0; idle(5); chk(tmr, 8'h01);
      cfg = 8'h07; idle(7); chk(pre, 8'h07);
      wr(ADDR_TIMER_COUNT, 8'h40); chk(pre, 8'h00);
      chk(tmr, 8'h40);
      $display("timer test done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // the whole run takes well under a thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      bad_count = 0; checked = 0; cycles = 0; reset_i = 1'b1; pin = 1'b0; cfg = 8'h08;
      ctl(CPS_PC_STEP, 1'b0, 1'b0, 1'b0, 3'h0);
      iword = 11'h000; raddr = 6'h00; wdata = 8'h00; aop = 3'h0; a = 8'h00; b = 8'h00;
      repeat (4) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      t_reset();
      t_status();
      t_flags();
      t_pc_load();
      t_stack();
      t_pointer();
      t_timer();
      wrap_up();
   end
endmodule
